// ### logic/ccs_regs.svh
// Register offsets, field positions and reset values of the chain sequencer.
// Assumes inclusion by bare name from the design module.
`ifndef CCS_REGS_SVH
`define CCS_REGS_SVH

// ----------------------------------------
// Byte offsets on the register bus
// ----------------------------------------
`define CCS_OFF_CTRL 5'h00
`define CCS_OFF_STAT 5'h04
`define CCS_OFF_CAW 5'h08
`define CCS_OFF_CCWA 5'h0C
`define CCS_OFF_CNT 5'h10
`define CCS_OFF_DADR 5'h14

// ----------------------------------------
// Control bits and address word fields
// ----------------------------------------
`define CCS_CTRL_START 0
`define CCS_CTRL_HALT 1
`define CCS_CTRL_CLR 2
`define CCS_CAW_KEY 31:28
`define CCS_CAW_ADDR 23:0

// ----------------------------------------
// Steps, limits and reset values
// ----------------------------------------
`define CCS_CHAIN_STEP 24'h000008
`define CCS_SMOD_STEP 24'h000010
`define CCS_PF_LIMIT 16'h000C
`define CCS_WAIT_RST 1'b1

`endif

// ### logic/ccs_pkg.sv
// Types shared by the chain sequencer and its bench.
// Assumes nothing beyond a SystemVerilog compiler.
package ccs_pkg;

	// ----------------------------------------
	// Modes and states
	// ----------------------------------------
	typedef enum logic [2:0] {S_IDLE, S_FETCH, S_DECODE, S_XFER, S_DMEM, S_PF, S_WAIT_END} ccs_state_t;
	typedef enum logic [2:0] {OP_INV, OP_OUT, OP_IN, OP_BACK, OP_BR} ccs_op_t;
	typedef enum logic [1:0] {CH_FIRST, CH_CMD, CH_DATA} ccs_chain_t;

	// ----------------------------------------
	// Words and status
	// ----------------------------------------
	typedef struct packed {
		logic [7:0] cmd;
		logic [23:0] addr;
		logic cd;
		logic cc;
		logic length_suppress_flag;
		logic skip;
		logic pci;
		logic [10:0] rsv;
		logic [15:0] count;
	} ccs_ccw_t;

	typedef struct packed {
		logic chk;
		logic prot;
		logic prog;
	} ccs_err_t;

	typedef struct packed {
		ccs_err_t err;
		logic at_start;
		logic int_pend;
		logic busy;
	} ccs_sts_t;

	// ----------------------------------------
	// Storage and device carriers
	// ----------------------------------------
	typedef struct packed {
		logic req;
		logic we;
		logic dword;
		logic lsel;
		logic [3:0] key;
		logic [23:0] addr;
		logic [7:0] wdata;
	} ccs_mem_req_t;

	typedef struct packed {
		logic ack;
		logic err;
		logic prot;
		logic stopped;
		logic [63:0] rdata;
	} ccs_mem_rsp_t;

	typedef struct packed {
		logic req;
		logic dev_end;
		logic stat_mod;
		logic unusual;
		logic [7:0] din;
	} ccs_dev_in_t;

	typedef struct packed {
		logic start;
		logic ack;
		logic term;
		logic [7:0] cmd;
		logic [7:0] dout;
	} ccs_dev_out_t;

	// ----------------------------------------
	// Whole state of the sequencer
	// ----------------------------------------
	typedef struct packed {
		ccs_state_t state;
		logic wr_n;
		logic [31:0] rdata;
		logic halt;
		logic [3:0] key;
		logic [23:0] channel_address_word;
		ccs_ccw_t channel_command_word;
		ccs_op_t op;
		logic [23:0] ccwa;
		ccs_chain_t chain;
		ccs_sts_t sts;
		ccs_ccw_t nw;
		logic pfv;
		ccs_err_t pfe;
		ccs_err_t pend;
		logic wrap;
		ccs_mem_req_t mem;
		ccs_dev_out_t dev;
	} ccs_st_t;

endpackage

// ### logic/ccs_chain_seq.sv
// Channel command chain sequencer: fetches command words, moves bytes, chains.
// Assumes a storage port that answers with ack and a device that holds req until ack.
//
// Operation
// - Classify by two low command bits; use four low bits when both zero.
// - Decode invalid, sense, branch, read backward, write, read, control from low bits.
// - High-order command bits are modifiers, ignored by the channel itself.
// - Pass the whole eight-bit command byte to the device at initiation.
// - Invalid first command: no start, status stored with program check.
// - Invalid command while command chaining: suppress operation, raise interruption condition.
// - Data chaining ignores the new command field unless it is a branch.
// - Address bits 8 and 9 both one select local machine storage.
// - Forward operations increment address and decrement count per byte.
// - Read backward decrements address and count; zero count exhausts the area.
// - Protected reference: protection check; terminate device or interrupt by chaining type.
// - Key protection applies to main storage only, never local machine storage.
// - Bad storage raises program check, reported at end of operation or chain.
// - Addresses never wrap to zero; running past the end is invalid.
// - Output data may be fetched ahead, at most twelve bytes buffered.
// - Next command word may be prefetched once twelve or fewer bytes remain.
// - Prefetch errors stay silent until used, dropped if operation ends first.
// - Zero count outside branch is program check; stored at start if first.
// - Zero count: terminate device when data chaining, interrupt when command chaining.
// - Next command word sits eight above current; chain keeps original device.
// - Branch target takes preceding chaining type; branch flags are ignored.
// - Word in logout-stopped storage: chaining check, handled by chaining type.
// - Command word layout: command, address, flags, count fields.
// - Status modifier with device end while command chaining skips sixteen ahead.
//
// The placing of the registers and the Avalon-MM register port were chosen for this implementation.
`timescale 1ns/1ps
`include "ccs_regs.svh"

module ccs_chain_seq #(
	parameter logic [15:0] PF_BYTES = `CCS_PF_LIMIT
) (
	input wire logic core_clk_i, // 20 MHz clock.
	input wire logic rst_n_i, // Asynchronous reset, active low.
	input wire logic [4:0] avs_address_i, // Byte address.
	input wire logic avs_read_i, // Read request.
	input wire logic avs_write_i, // Write request.
	input wire logic [31:0] avs_writedata_i, // Write data.
	output logic [31:0] avs_readdata_o, // Read data.
	output logic avs_waitrequest_o, // Low for one answer cycle.
	output ccs_pkg::ccs_mem_req_t mem_o, // Storage request.
	input wire ccs_pkg::ccs_mem_rsp_t mem_i, // Storage answer.
	output ccs_pkg::ccs_dev_out_t dev_o, // To control unit.
	input wire ccs_pkg::ccs_dev_in_t dev_i // From control unit.
);
	import ccs_pkg::*;

	ccs_st_t q;
	ccs_st_t d;

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	// Only the low nibble matters; modifier bits never reach the decode.
	function automatic ccs_op_t dec(input logic [7:0] c);
		unique case (c[1:0])
			2'b01: dec = OP_OUT;
			2'b10: dec = OP_IN;
			2'b11: dec = OP_OUT;
			2'b00: begin
				unique case (c[3:2])
					2'b00: dec = OP_INV;
					2'b01: dec = OP_IN;
					2'b10: dec = OP_BR;
					2'b11: dec = OP_BACK;
				endcase
			end
		endcase
	endfunction

	// Upper bit flags a step past either end of storage.
	function automatic logic [24:0] step(input logic [23:0] a, input logic back);
		if (back) begin
			step = {a == 24'h000000, a - 24'h000001};
		end else begin
			step = {1'b0, a} + 25'h0000001;
		end
	endfunction

	// ----------------------------------------
	// Next state
	// ----------------------------------------
	// Order after the case: byte advance, device end, fetch launch, failure.
	always_comb begin
		ccs_err_t e;
		ccs_err_t fe;
		ccs_op_t o;
		logic [24:0] nx;
		logic [23:0] fa;
		logic fail;
		logic fet;
		logic adv;
		logic go;
		logic bad;
		d = q;
		fe = '0;
		fa = q.ccwa;
		fail = 1'b0;
		fet = 1'b0;
		adv = 1'b0;
		o = dec(q.nw.cmd);
		nx = step(q.channel_command_word.addr, q.op == OP_BACK);
		e.chk = mem_i.stopped;
		e.prot = mem_i.prot && !q.mem.lsel;
		e.prog = mem_i.err;
		d.dev.start = 1'b0;
		d.dev.ack = 1'b0;
		d.wr_n = `CCS_WAIT_RST;
		go = 1'b0;
		bad = q.pend != '0 || q.dev.term || q.halt || dev_i.unusual;

		// Bus: answer one cycle after the request, act when waitrequest is low.
		if ((avs_read_i || avs_write_i) && q.wr_n) begin
			d.wr_n = 1'b0;
			unique case (avs_address_i)
				`CCS_OFF_STAT: d.rdata = {26'h0000000, q.sts};
				`CCS_OFF_CAW: d.rdata = {q.key, 4'h0, q.channel_address_word};
				`CCS_OFF_CCWA: d.rdata = {8'h00, q.ccwa};
				`CCS_OFF_CNT: d.rdata = {q.channel_command_word.cmd, 8'h00, q.channel_command_word.count};
				`CCS_OFF_DADR: d.rdata = {7'h00, q.wrap, q.channel_command_word.addr};
				default: d.rdata = 32'h00000000;
			endcase
		end
		if (avs_write_i && !q.wr_n) begin
			if (avs_address_i == `CCS_OFF_CTRL) begin
				if (avs_writedata_i[`CCS_CTRL_CLR]) begin
					d.sts.err = '0;
					d.sts.at_start = 1'b0;
					d.sts.int_pend = 1'b0;
				end
				d.halt = q.halt || (avs_writedata_i[`CCS_CTRL_HALT] && q.sts.busy);
				go = avs_writedata_i[`CCS_CTRL_START] && !q.sts.busy;
			end else if (avs_address_i == `CCS_OFF_CAW && !q.sts.busy) begin
				d.key = avs_writedata_i[`CCS_CAW_KEY];
				d.channel_address_word = avs_writedata_i[`CCS_CAW_ADDR];
			end
		end

		// Sequencer proper.
		unique case (q.state)
			S_IDLE: begin
				if (go) begin
					d.chain = CH_FIRST;
					d.ccwa = q.channel_address_word;
					d.sts.busy = 1'b1;
					d.pend = '0;
					d.pfv = 1'b0;
					d.halt = 1'b0;
					d.dev.term = 1'b0;
					if (q.channel_address_word[2:0] != 3'h0) begin
						fe.prog = 1'b1;
						fail = 1'b1;
					end else begin
						fet = 1'b1;
						fa = q.channel_address_word;
					end
				end
			end
			S_FETCH: begin
				if (mem_i.ack) begin
					d.mem.req = 1'b0;
					if (e != '0) begin
						fe = e;
						fail = 1'b1;
					end else begin
						d.nw = mem_i.rdata;
						d.state = S_DECODE;
					end
				end
			end
			S_DECODE: begin
				if (o == OP_BR) begin
					// Chain type is left as it was, and the branch flags are never loaded.
					if (q.nw.addr[2:0] != 3'h0) begin
						fe.prog = 1'b1;
						fail = 1'b1;
					end else begin
						fet = 1'b1;
						fa = q.nw.addr;
					end
				end else if (q.chain != CH_DATA && o == OP_INV) begin
					fe.prog = 1'b1;
					fail = 1'b1;
				end else if (q.nw.count == 16'h0000) begin
					fe.prog = 1'b1;
					fail = 1'b1;
				end else begin
					d.channel_command_word = q.nw;
					d.wrap = 1'b0;
					d.state = S_XFER;
					if (q.chain == CH_DATA) begin
						d.channel_command_word.cmd = q.channel_command_word.cmd;
					end else begin
						d.op = o;
						d.dev.cmd = q.nw.cmd;
						d.dev.start = 1'b1;
					end
				end
			end
			S_XFER: begin
				if (q.halt) begin
					d.halt = 1'b0;
					d.pfv = 1'b0;
					d.dev.term = 1'b1;
					d.state = S_WAIT_END;
				end else if (dev_i.req && !q.dev.ack) begin // A request just acknowledged still stands one cycle.
					if (q.channel_command_word.count == 16'h0000) begin
						d.dev.term = 1'b1;
						d.state = S_WAIT_END;
					end else if (q.wrap) begin
						d.pend.prog = 1'b1;
						d.dev.term = 1'b1;
						d.state = S_WAIT_END;
					end else if (q.channel_command_word.skip && q.op != OP_OUT) begin
						adv = 1'b1;
					end else begin
						d.mem.req = 1'b1;
						d.mem.we = q.op != OP_OUT;
						d.mem.dword = 1'b0;
						d.mem.addr = q.channel_command_word.addr;
						d.mem.lsel = q.channel_command_word.addr[23] && q.channel_command_word.addr[22];
						d.mem.wdata = dev_i.din;
						d.state = S_DMEM;
					end
				end else if (q.op == OP_OUT && q.channel_command_word.cd && !q.pfv && q.channel_command_word.count <= PF_BYTES) begin
					// Word prefetch only; data bytes are fetched on demand, well under the buffer cap.
					d.mem.req = 1'b1;
					d.mem.we = 1'b0;
					d.mem.dword = 1'b1;
					d.mem.addr = q.ccwa + `CCS_CHAIN_STEP;
					d.mem.lsel = d.mem.addr[23] && d.mem.addr[22];
					d.state = S_PF;
				end
			end
			S_PF: begin
				if (mem_i.ack) begin
					d.mem.req = 1'b0;
					d.nw = mem_i.rdata;
					d.pfe = e;
					d.pfv = 1'b1;
					d.state = S_XFER;
				end
			end
			S_DMEM: begin
				if (mem_i.ack) begin
					d.mem.req = 1'b0;
					if (e.prot || e.prog) begin
						d.pend = q.pend | e;
						d.dev.term = 1'b1;
						d.state = S_WAIT_END;
					end else begin
						d.dev.dout = mem_i.rdata[7:0];
						adv = 1'b1;
					end
				end
			end
			S_WAIT_END: begin
			end
		endcase

		// One byte done: step address and count, then chain data if exhausted.
		if (adv) begin
			d.dev.ack = 1'b1;
			d.channel_command_word.addr = nx[23:0];
			d.wrap = nx[24];
			d.channel_command_word.count = q.channel_command_word.count - 16'h0001;
			d.state = S_XFER;
			if (q.channel_command_word.count == 16'h0001 && q.channel_command_word.cd) begin
				d.chain = CH_DATA;
				if (q.pfv) begin
					d.pfv = 1'b0;
					d.ccwa = q.ccwa + `CCS_CHAIN_STEP;
					if (q.pfe != '0) begin
						fe = q.pfe;
						fail = 1'b1;
					end else begin
						d.state = S_DECODE;
					end
				end else begin
					fet = 1'b1;
					fa = q.ccwa + `CCS_CHAIN_STEP;
				end
			end
		end

		// Device end closes the operation or chains the next command.
		if ((q.state == S_XFER || q.state == S_WAIT_END) && dev_i.dev_end) begin
			d.pfv = 1'b0;
			d.dev.term = 1'b0;
			d.halt = 1'b0;
			if (!bad && q.channel_command_word.cc && !q.channel_command_word.cd) begin
				d.chain = CH_CMD;
				fet = 1'b1;
				fa = q.ccwa + (dev_i.stat_mod ? `CCS_SMOD_STEP : `CCS_CHAIN_STEP);
			end else begin
				d.sts.err = d.sts.err | q.pend;
				d.sts.int_pend = 1'b1;
				d.sts.busy = 1'b0;
				d.pend = '0;
				d.state = S_IDLE;
			end
		end

		// Launch a command word fetch in the storage of its own address.
		if (fet) begin
			d.ccwa = fa;
			d.mem.req = 1'b1;
			d.mem.we = 1'b0;
			d.mem.dword = 1'b1;
			d.mem.addr = fa;
			d.mem.lsel = fa[23] && fa[22];
			d.mem.key = q.key;
			d.state = S_FETCH;
		end

		// A failure is handled by the chaining type in force.
		if (fail) begin
			d.mem.req = 1'b0;
			unique case (d.chain)
				CH_FIRST: begin
					d.sts.err = d.sts.err | fe;
					d.sts.at_start = 1'b1;
					d.sts.busy = 1'b0;
					d.state = S_IDLE;
				end
				CH_CMD: begin
					d.sts.err = d.sts.err | fe;
					d.sts.int_pend = 1'b1;
					d.sts.busy = 1'b0;
					d.state = S_IDLE;
				end
				CH_DATA: begin
					d.pend = d.pend | fe;
					d.dev.term = 1'b1;
					d.state = S_WAIT_END;
				end
			endcase
		end
	end

	// ----------------------------------------
	// State register
	// ----------------------------------------
	// Reset gives idle, no requests and waitrequest high.
	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			q <= '0;
			q.wr_n <= `CCS_WAIT_RST;
		end else begin
			q <= d;
		end
	end

	// Every output is a field of the state register.
	assign avs_readdata_o = q.rdata;
	assign avs_waitrequest_o = q.wr_n;
	assign mem_o = q.mem;
	assign dev_o = q.dev;

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	default clocking cb @(posedge core_clk_i);
	endclocking
	default disable iff (!rst_n_i);

	a_cmd_byte_whole: assert property (dev_o.start |-> dev_o.cmd == q.channel_command_word.cmd && q.state == S_XFER)
		else $error("command byte to device differs from word");
	a_local_select: assert property (mem_o.req |-> mem_o.lsel == (mem_o.addr[23] && mem_o.addr[22]))
		else $error("storage select does not follow address bits");
	a_local_unprot: assert property (q.state == S_DMEM && mem_i.ack && mem_o.lsel && !mem_i.err
		|=> q.pend.prot == $past(q.pend.prot) && q.state != S_WAIT_END)
		else $error("protection applied to local storage");
	a_fwd_step: assert property (q.state == S_DMEM && mem_i.ack && !mem_i.err && !mem_i.prot && q.op != OP_BACK
		|=> (q.channel_command_word.addr == $past(q.channel_command_word.addr) + 24'h000001 || q.wrap)
		&& q.channel_command_word.count == $past(q.channel_command_word.count) - 16'h0001 && dev_o.ack)
		else $error("forward step wrong");
	a_back_step: assert property (q.state == S_DMEM && mem_i.ack && !mem_i.err && !mem_i.prot && q.op == OP_BACK
		|=> (q.channel_command_word.addr == $past(q.channel_command_word.addr) - 24'h000001 || q.wrap)
		&& q.channel_command_word.count == $past(q.channel_command_word.count) - 16'h0001)
		else $error("backward step wrong");
	a_first_invalid: assert property (q.state == S_DECODE && q.chain == CH_FIRST && q.nw.cmd[3:0] == 4'h0
		|=> q.state == S_IDLE && q.sts.at_start && q.sts.err.prog ##1 !dev_o.start)
		else $error("invalid first command started");
	a_zero_count: assert property (q.state == S_DECODE && q.nw.count == 16'h0000 && q.nw.cmd[3:0] != 4'h8
		|=> q.state != S_XFER && !dev_o.start)
		else $error("zero count accepted");
	a_chain_eight: assert property ((q.state == S_XFER || q.state == S_WAIT_END) && dev_i.dev_end
		&& q.channel_command_word.cc && !q.channel_command_word.cd && !dev_i.unusual && q.pend == '0 && !q.dev.term && !q.halt && !dev_i.stat_mod
		|=> mem_o.req && mem_o.dword && mem_o.addr == $past(q.ccwa) + 24'h000008)
		else $error("chained word not eight above");
	a_chain_sixteen: assert property ((q.state == S_XFER || q.state == S_WAIT_END) && dev_i.dev_end
		&& q.channel_command_word.cc && !q.channel_command_word.cd && !dev_i.unusual && q.pend == '0 && !q.dev.term && !q.halt && dev_i.stat_mod
		|=> mem_o.addr == $past(q.ccwa) + 24'h000010)
		else $error("status modifier chain not sixteen above");
	a_prefetch_late: assert property (q.state == S_PF |-> q.channel_command_word.count <= PF_BYTES && q.channel_command_word.count != 16'h0000)
		else $error("word prefetched too early");
	a_wrap_stops: assert property (q.state == S_XFER && q.wrap && dev_i.req && !dev_o.ack && q.channel_command_word.count != 16'h0000
		|=> dev_o.term && q.state == S_WAIT_END)
		else $error("transfer continued past storage end");

endmodule

// ### verification/ccs_far_model.sv
// Far side of the chain sequencer: byte storage with keys and a byte-wide control unit.
// Assumes the sequencer's storage and device carriers from ccs_pkg and one shared clock.
`timescale 1ns/1ps

module ccs_far_model (
	input wire logic core_clk_i, // Shared clock.
	input wire logic rst_n_i, // Reset, active low.
	input wire ccs_pkg::ccs_mem_req_t mem_req_i, // Storage request from the sequencer.
	output ccs_pkg::ccs_mem_rsp_t mem_rsp_o, // Storage answer.
	input wire ccs_pkg::ccs_dev_out_t dev_out_i, // Signals from the sequencer to the unit.
	output ccs_pkg::ccs_dev_in_t dev_in_o, // Signals from the unit to the sequencer.
	input wire logic slow_i, // Adds a wait cycle before each storage answer.
	input wire logic [15:0] nbytes_i, // Bytes the unit moves per operation.
	input wire logic smod_i // Status modifier shown with device end.
);
	import ccs_pkg::*;
	localparam logic [3:0] STORE_KEY = 4'h3; // Key of every main storage block.
	logic [7:0] mem [0:4095];
	logic [15:0] left;
	logic busy;
	logic waited;
	logic [11:0] a;
	assign a = mem_req_i.addr[11:0];

	// Storage answers after zero or one wait cycle; read data toggles outside answers so stale data never matches.
	always @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			mem_rsp_o <= '0;
			waited <= 1'b0;
		end else begin
			mem_rsp_o.ack <= 1'b0;
			mem_rsp_o.err <= 1'b0;
			mem_rsp_o.prot <= 1'b0;
			mem_rsp_o.stopped <= 1'b0;
			mem_rsp_o.rdata <= ~mem_rsp_o.rdata;
			if (mem_req_i.req && !mem_rsp_o.ack && (waited || !slow_i)) begin
				mem_rsp_o.ack <= 1'b1;
				waited <= 1'b0;
				mem_rsp_o.err <= !mem_req_i.lsel && mem_req_i.addr[23:12] != 12'h000;
				mem_rsp_o.prot <= mem_req_i.key != STORE_KEY;
				mem_rsp_o.stopped <= a[11:8] == 4'hE;
				mem_rsp_o.rdata <= mem_req_i.dword ? {mem[a], mem[a + 12'h1], mem[a + 12'h2], mem[a + 12'h3],
					mem[a + 12'h4], mem[a + 12'h5], mem[a + 12'h6], mem[a + 12'h7]} : {56'h0, mem[a]};
				if (mem_req_i.we) begin
					mem[a] <= mem_req_i.wdata;
				end
			end else if (mem_req_i.req && !mem_rsp_o.ack) begin
				waited <= 1'b1;
			end
		end
	end

	// The unit asks for one byte at a time and ends with a device end pulse; term cuts it short.
	always @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			dev_in_o <= '0;
			left <= '0;
			busy <= 1'b0;
		end else begin
			dev_in_o.dev_end <= 1'b0;
			dev_in_o.stat_mod <= smod_i;
			if (dev_out_i.start) begin
				busy <= 1'b1;
				left <= nbytes_i;
				dev_in_o.req <= 1'b1;
				dev_in_o.din <= {4'h5, nbytes_i[3:0]};
			end else if (busy && dev_out_i.term) begin
				busy <= 1'b0;
				dev_in_o.req <= 1'b0;
				dev_in_o.dev_end <= 1'b1;
			end else if (dev_in_o.req && dev_out_i.ack) begin
				dev_in_o.req <= 1'b0;
				left <= left - 16'h0001;
				dev_in_o.din <= ~dev_in_o.din;
			end else if (busy && !dev_in_o.req) begin
				if (left == 16'h0000) begin
					busy <= 1'b0;
					dev_in_o.dev_end <= 1'b1;
				end else begin
					dev_in_o.req <= 1'b1;
					dev_in_o.din <= {4'h5, left[3:0]};
				end
			end
		end
	end
endmodule

// ### verification/tb_top.sv
// Self-checking bench for the chain sequencer with a far side model and an event scoreboard.
// Assumes the package, the design and the far side model are compiled ahead of it.
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin total_checks++; if ((got) !== (ex)) begin fails++; \
	$display("CHECK FAILED %s expected %h seen %h", nm, ex, got); end end

module tb_top;
	import ccs_pkg::*;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic [4:0] addr = '0;
	logic rd = 1'b0;
	logic wr = 1'b0;
	logic [31:0] wdata = '0;
	logic [31:0] rdata;
	logic waitreq;
	logic [31:0] rd_val;
	ccs_mem_req_t mem_req;
	ccs_mem_rsp_t mem_rsp;
	ccs_dev_out_t dev_out;
	ccs_dev_in_t dev_in;
	logic slow = 1'b0;
	logic quiet = 1'b0;
	logic smod = 1'b0;
	logic [7:0] cur_cmd = '0;
	logic [39:0] expq [$];
	logic [31:0] seed = 32'hF7CF12D3;
	int fails = 0;
	int total_checks = 0;
	int cyc = 0;
	logic [7:0] cmds [6] = '{8'h81, 8'h42, 8'h4C, 8'h23, 8'hE4, 8'hF0};

	ccs_chain_seq #(.PF_BYTES(16'h000C)) dut_u (.core_clk_i(clk), .rst_n_i(rst_n), .avs_address_i(addr),
		.avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wdata), .avs_readdata_o(rdata),
		.avs_waitrequest_o(waitreq), .mem_o(mem_req), .mem_i(mem_rsp), .dev_o(dev_out), .dev_i(dev_in));
	ccs_far_model far_u (.core_clk_i(clk), .rst_n_i(rst_n), .mem_req_i(mem_req), .mem_rsp_o(mem_rsp),
		.dev_out_i(dev_out), .dev_in_o(dev_in), .slow_i(slow), .nbytes_i(16'h0002), .smod_i(smod));

	// 20 MHz clock.
	initial begin
		forever #25 clk = ~clk;
	end

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	function automatic logic [31:0] xs(input logic [31:0] s);
		logic [31:0] x;
		x = s ^ (s << 13);
		x = x ^ (x >> 17);
		return x ^ (x << 5);
	endfunction

	task automatic wrap_up;
		$display("Checks made: %0d, mismatches: %0d", total_checks, fails);
		if (fails == 0 && total_checks > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	task automatic take(input logic [3:0] k, input logic [35:0] v);
		logic [39:0] e;
		e = expq.size() == 0 ? '1 : expq.pop_front();
		`CHK("event", e, {k, v})
	endtask

	// One bus transfer; the request stands until waitrequest is sampled low, then an edge passes.
	task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
		addr <= a;
		wdata <= d;
		wr <= w;
		rd <= !w;
		@(posedge clk);
		while (waitreq !== 1'b0) begin
			@(posedge clk);
		end
		rd_val = rdata;
		wr <= 1'b0;
		rd <= 1'b0;
		@(posedge clk);
	endtask

	task automatic put_ccw(input logic [11:0] a, input logic [63:0] w);
		for (int i = 0; i < 8; i++) far_u.mem[a + 12'(i)] = w[63 - 8 * i -: 8];
	endtask

	// Places a command word and notes the start and byte events it should cause.
	task automatic prep(input logic [7:0] cmd, input logic [23:0] ca, input logic [23:0] da, input logic [7:0] fl,
			input logic [15:0] cnt, input logic go);
		logic [7:0] b;
		logic [23:0] a;
		put_ccw(ca[11:0], {cmd, da, fl, 8'h00, cnt});
		if (go) expq.push_back({4'h1, 28'h0, cmd});
		for (int i = 0; i < cnt && go; i++) begin
			a = cmd[3:0] == 4'hC ? da - 24'(i) : da + 24'(i);
			b = seed[7:0];
			seed = xs(seed);
			if (cmd[0]) begin
				far_u.mem[a[11:0]] = b;
				expq.push_back({4'h2, 28'h0, b});
			end else begin
				expq.push_back({4'h3, 3'h0, da[23] & da[22], a, 8'h52 - 8'(i)});
			end
		end
	endtask

	// Starts from an address word, polls until idle, then checks status and clears it.
	task automatic run(input logic [23:0] ca, input logic [3:0] key, input logic [31:0] stat);
		logic seen;
		int n;
		seen = 1'b0;
		n = 0;
		bus(1'b1, 5'h08, {key, 4'h0, ca});
		bus(1'b1, 5'h00, 32'h1);
		quiet = 1'b1;
		do begin
			bus(1'b0, 5'h04, 32'h0);
			seen = seen | rd_val[0];
			n++;
		end while ((rd_val[0] !== 1'b0 || (!seen && rd_val[5:2] === 4'h0)) && n < 300);
		quiet = 1'b0;
		expq.push_back({4'h4, 4'h0, stat});
		bus(1'b0, 5'h04, 32'h0);
		bus(1'b1, 5'h00, 32'h4);
		slow <= ~slow;
	endtask

	// ----------------------------------------
	// Scoreboard and timeout
	// ----------------------------------------
	// Every observed result takes the oldest note; a stray event finds a mismatch or an empty queue.
	always @(posedge clk) begin
		if (rst_n) begin
			if (dev_out.start === 1'b1) begin
				take(4'h1, {28'h0, dev_out.cmd});
				cur_cmd = dev_out.cmd;
			end
			if (dev_out.ack === 1'b1 && cur_cmd[0]) take(4'h2, {28'h0, dev_out.dout});
			if (mem_req.req === 1'b1 && mem_req.we === 1'b1 && mem_rsp.ack)
				take(4'h3, {3'h0, mem_req.lsel, mem_req.addr, mem_req.wdata});
			if (rd && waitreq === 1'b0 && !quiet) take(4'h4, {4'h0, rdata});
		end
	end

	// A hang counts as a mismatch and still reaches the verdict.
	always @(posedge clk) begin
		cyc++;
		if (cyc == 40000) begin
			fails++;
			wrap_up();
		end
	end

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		repeat (12) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		expq.push_back({4'h4, 36'h0});
		bus(1'b0, 5'h04, 32'h0);
		expq.push_back({4'h4, 36'h0});
		bus(1'b0, 5'h1C, 32'h0);
		// Every operation class except branch once, with modifier bits set.
		for (int i = 0; i < 6; i++) begin
			prep(cmds[i], 24'h000100, 24'h000200, 8'h00, 16'h0002, cmds[i][3:0] != 4'h0);
			run(24'h000100, 4'h3, cmds[i][3:0] != 4'h0 ? 32'h2 : 32'hC);
		end
		// A wrong key passes in local storage and fails in main storage.
		prep(8'h81, 24'hC00100, 24'hC00200, 8'h00, 16'h0002, 1'b1);
		run(24'hC00100, 4'h5, 32'h2);
		prep(8'h81, 24'h000100, 24'h000200, 8'h00, 16'h0002, 1'b0);
		run(24'h000100, 4'h5, 32'h14);
		// Faults in the first word: zero count, misaligned address, stopped element.
		prep(8'h01, 24'h000100, 24'h000200, 8'h00, 16'h0000, 1'b0);
		run(24'h000100, 4'h3, 32'hC);
		run(24'h000104, 4'h3, 32'hC);
		prep(8'h01, 24'h000E00, 24'h000200, 8'h00, 16'h0002, 1'b0);
		run(24'h000E00, 4'h3, 32'h24);
		// A branch as the first word.
		prep(8'h05, 24'h000180, 24'h000200, 8'h00, 16'h0002, 1'b1);
		put_ccw(12'h140, {8'h08, 24'h000180, 32'h0});
		run(24'h000140, 4'h3, 32'h2);
		// Command chain through a branch whose own flags ask for data chaining.
		prep(8'h01, 24'h000100, 24'h000200, 8'h40, 16'h0002, 1'b1);
		put_ccw(12'h108, {8'h08, 24'h000180, 8'h80, 24'h0});
		prep(8'hE4, 24'h000180, 24'h000300, 8'h00, 16'h0002, 1'b1);
		run(24'h000100, 4'h3, 32'h2);
		// An invalid word met by command chaining; a valid word waits one slot too far.
		prep(8'h01, 24'h000100, 24'h000200, 8'h40, 16'h0002, 1'b1);
		put_ccw(12'h108, {8'h00, 24'h000200, 32'h1});
		put_ccw(12'h110, {8'h01, 24'h000200, 32'h1});
		run(24'h000100, 4'h3, 32'hA);
		// Status modifier with device end chains sixteen above; the word eight above is invalid.
		smod <= 1'b1;
		prep(8'h01, 24'h000100, 24'h000200, 8'h40, 16'h0002, 1'b1);
		put_ccw(12'h108, {8'h00, 24'h000200, 32'h1});
		prep(8'h42, 24'h000110, 24'h000300, 8'h00, 16'h0002, 1'b1);
		run(24'h000100, 4'h3, 32'h2);
		smod <= 1'b0;
		// Output data chaining: the next word is prefetched and its invalid command field is ignored.
		prep(8'h01, 24'h000100, 24'h000200, 8'h80, 16'h0002, 1'b1);
		put_ccw(12'h108, {8'h00, 24'h000300, 32'h2});
		run(24'h000100, 4'h3, 32'h2);
		`CHK("queue left", 0, expq.size())
		wrap_up();
	end
endmodule
